/* File: common/hp_chain_pkg.sv */
// shared constants for the hot-plug slot serial shift chain
package hp_chain_pkg;

  // chain geometry
  localparam int SLOTS_PER_DEVICE = 2;
  localparam int BITS_PER_SLOT = 8;
  localparam int LOCAL_BITS = SLOTS_PER_DEVICE * BITS_PER_SLOT;
  localparam int CHAIN_SLOTS = 6;
  localparam int CHAIN_BITS = CHAIN_SLOTS * BITS_PER_SLOT;
  localparam int ADDR_BITS = 3;

  // input channel codes
  localparam logic [1:0] CH_IRQ = 2'h0;
  localparam logic [1:0] CH_NONIRQ = 2'h1;
  localparam logic [1:0] CH_DIAG1 = 2'h2;
  localparam logic [1:0] CH_DIAG2 = 2'h3;

  // operational mode needs both mode pins high
  localparam logic [1:0] MODE_OPERATIONAL = 2'h3;

  // output control byte fields per slot
  localparam int CT_PWREN = 0;
  localparam int CT_CLKEN = 1;
  localparam int CT_BUSEN = 2;
  localparam int CT_RESET = 3;
  localparam int CT_PLED = 4;
  localparam int CT_ALED = 5;

  // power-good initial pin states
  localparam logic INIT_LED = 1'h1;
  localparam logic INIT_ENABLE_N = 1'h1;
  localparam logic INIT_RESET_N = 1'h0;
  localparam logic INIT_PWREN = 1'h0;
  localparam logic DEVICE_PRESENT = 1'h1;
  localparam logic DIAG_ONE = 1'h1;

  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int LINK_PERIOD_NS = 160;
  localparam int LINK_HALF_CYCLES = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  // readback buffer shape
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 32;

endpackage

/* File: common/hp_chain_if.sv */
// serial link between the hot-plug controller and the nearest slot device
interface hp_chain_if;
  logic status_shift_clock;
  logic status_load_select;
  logic status_chain_out;
  logic control_shift_clock;
  logic control_chain_in;
  logic control_latch_clock;
  logic reset_latch_clock;

  modport device
  (
    input status_shift_clock,
    input status_load_select,
    output status_chain_out,
    input control_shift_clock,
    input control_chain_in,
    input control_latch_clock,
    input reset_latch_clock
  );

  modport host
  (
    output status_shift_clock,
    output status_load_select,
    input status_chain_out,
    output control_shift_clock,
    output control_chain_in,
    output control_latch_clock,
    output reset_latch_clock
  );
endinterface

/* File: core/hp_slot_device.sv */
// two-slot hot-plug power controller: serial status and control shift chain
// Notes on behaviour
// - channel codes select irq, non-irq, diag1, diag2
// - downstream status bits pass through shift register
// - own 16 bits first, downstream bits follow
// - channel 00: interlock, button, fault, presence bits
// - channel 01: m66, pcix caps, aux fault
// - channel 10: pin states of slot controls
// - channel 10 bits 0 and 8 read one
// - channel 11: latched mode bits, bit 2 one
// - status leaves slot a first, then cascade
// - control shifted last slot first, 8 bits each
// - host shifts whole chain for any change
// - nearest device ends holding slots a and b
// - control byte: pwren, clk, bus, reset, leds
// - control shift clock moves bits, overflow forwarded
// - main latch copies enables and leds
// - reset latch updates only slot reset
// - slot fault forces reset, drops clk, bus
// - start bit low, then lsb, msb, reserved
// - operational at power-good rise, modes 11, test 0
// - power-good rise initialises outputs
module hp_slot_device
(
  input wire logic clk_sys,
  input wire logic srst,
  hp_chain_if.device link,
  input wire logic status_chain_in,
  output logic control_chain_out,
  input wire logic power_good_in,
  input wire logic test_in,
  input wire logic [1:0] mode_in,
  input wire logic [1:0] slot_interlock_open,
  input wire logic [1:0] slot_button,
  input wire logic [1:0] slot_main_fault_n,
  input wire logic [1:0] slot_aux_fault_n,
  input wire logic [1:0] slot_present2,
  input wire logic [1:0] slot_present1,
  input wire logic [1:0] slot_m66_enable,
  input wire logic [1:0] slot_pcix_cap1,
  input wire logic [1:0] slot_pcix_cap2,
  output logic [1:0] slot_power_enable,
  output logic [1:0] slot_clock_enable_n,
  output logic [1:0] slot_bus_enable_n,
  output logic [1:0] slot_reset_out_n,
  output logic [1:0] power_indicator,
  output logic [1:0] attention_indicator,
  output logic operational
);

  localparam int NS = hp_chain_pkg::SLOTS_PER_DEVICE;
  localparam int NB = hp_chain_pkg::BITS_PER_SLOT;
  localparam int NL = hp_chain_pkg::LOCAL_BITS;
  localparam int SYNC_W = 11 + 9 * NS;

  typedef enum logic [2:0]
  {
    IN_IDLE = 3'h0,
    IN_LSB = 3'h1,
    IN_MSB = 3'h3,
    IN_RSV = 3'h2,
    IN_SHIFT = 3'h6
  } in_state_type;

  // every pin passes two flops; only the second stage is read
  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_meta;
  logic [SYNC_W-1:0] sync_q;

  assign sync_raw = {link.status_shift_clock, link.status_load_select, link.control_shift_clock,
    link.control_chain_in, link.control_latch_clock, link.reset_latch_clock, status_chain_in,
    power_good_in, test_in, mode_in, slot_interlock_open, slot_button, slot_main_fault_n,
    slot_aux_fault_n, slot_present2, slot_present1, slot_m66_enable, slot_pcix_cap1,
    slot_pcix_cap2};

  always_ff @(posedge clk_sys)
  begin
    sync_meta <= sync_raw;
    sync_q <= sync_meta;
  end

  logic s_clk, s_sel, c_clk, c_data, l_clk, r_clk, s_chain, pg, test_q;
  logic [1:0] mode_q, interlock_q, button_q, mfault_n_q, afault_n_q;
  logic [1:0] pres2_q, pres1_q, m66_q, cap1_q, cap2_q;

  assign {s_clk, s_sel, c_clk, c_data, l_clk, r_clk, s_chain, pg, test_q, mode_q, interlock_q,
    button_q, mfault_n_q, afault_n_q, pres2_q, pres1_q, m66_q, cap1_q, cap2_q} = sync_q;

  // edge detection on the synchronised link clocks and power-good
  logic s_clk_d, c_clk_d, l_clk_d, r_clk_d, pg_d;
  logic s_rise, c_rise, l_rise, r_rise, pg_rise;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      s_clk_d <= 1'h0;
      c_clk_d <= 1'h0;
      l_clk_d <= 1'h0;
      r_clk_d <= 1'h0;
      pg_d <= 1'h0;
    end
    else
    begin
      s_clk_d <= s_clk;
      c_clk_d <= c_clk;
      l_clk_d <= l_clk;
      r_clk_d <= r_clk;
      pg_d <= pg;
    end
  end

  assign s_rise = s_clk & ~s_clk_d;
  assign c_rise = c_clk & ~c_clk_d;
  assign l_rise = l_clk & ~l_clk_d;
  assign r_rise = r_clk & ~r_clk_d;
  assign pg_rise = pg & ~pg_d;

  // mode capture at power-good rise; dropping power-good leaves the chain idle
  logic [1:0] mode_latched;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      operational <= 1'h0;
      mode_latched <= 2'h0;
    end
    else if (pg_rise)
    begin
      operational <= (mode_q == hp_chain_pkg::MODE_OPERATIONAL) && !test_q;
      mode_latched <= mode_q;
    end
    else if (!pg)
    begin
      operational <= 1'h0;
    end
  end

  // per-slot status bytes and control latches
  logic [NS-1:0][NB-1:0] irq_byte, nonirq_byte, diag1_byte, diag2_byte;
  logic [NL-1:0] out_sr;

  for (genvar s = 0; s < NS; s++)
  begin : g_slot
    logic fault_n;
    logic [NB-1:0] ctl;

    assign fault_n = mfault_n_q[s] & afault_n_q[s];
    // slot a sits at the top byte once all slots are shifted
    assign ctl = out_sr[(NS - 1 - s) * NB +: NB];

    // reserved positions are constant zero
    assign irq_byte[s] = {3'h0, pres1_q[s], pres2_q[s], fault_n, button_q[s],
      interlock_q[s]};
    assign nonirq_byte[s] = {4'h0, afault_n_q[s], cap2_q[s], cap1_q[s], m66_q[s]};
    assign diag1_byte[s] = {1'h0, attention_indicator[s], power_indicator[s],
      slot_reset_out_n[s], slot_bus_enable_n[s], slot_clock_enable_n[s],
      slot_power_enable[s], hp_chain_pkg::DEVICE_PRESENT};
    assign diag2_byte[s] = {5'h00, hp_chain_pkg::DIAG_ONE, mode_latched};

    // fault override comes last so it beats a latch clock in the same cycle;
    // it reacts a few cycles after the pin because the pin is synchronised
    always_ff @(posedge clk_sys)
    begin
      if (srst || pg_rise)
      begin
        slot_power_enable[s] <= hp_chain_pkg::INIT_PWREN;
        slot_clock_enable_n[s] <= hp_chain_pkg::INIT_ENABLE_N;
        slot_bus_enable_n[s] <= hp_chain_pkg::INIT_ENABLE_N;
        slot_reset_out_n[s] <= hp_chain_pkg::INIT_RESET_N;
        power_indicator[s] <= hp_chain_pkg::INIT_LED;
        attention_indicator[s] <= hp_chain_pkg::INIT_LED;
      end
      else
      begin
        if (operational && l_rise)
        begin
          slot_power_enable[s] <= ctl[hp_chain_pkg::CT_PWREN];
          slot_clock_enable_n[s] <= ~ctl[hp_chain_pkg::CT_CLKEN];
          slot_bus_enable_n[s] <= ~ctl[hp_chain_pkg::CT_BUSEN];
          power_indicator[s] <= ctl[hp_chain_pkg::CT_PLED];
          attention_indicator[s] <= ctl[hp_chain_pkg::CT_ALED];
        end
        if (operational && r_rise)
        begin
          slot_reset_out_n[s] <= ctl[hp_chain_pkg::CT_RESET];
        end
        if (!fault_n)
        begin
          slot_reset_out_n[s] <= 1'h0;
          slot_clock_enable_n[s] <= 1'h1;
          slot_bus_enable_n[s] <= 1'h1;
        end
      end
    end
  end

  // channel selection and status shift
  in_state_type in_state;
  logic [1:0] chan_addr;
  logic [NL-1:0] in_sr;
  logic [NL-1:0] local_word;

  always_comb
  begin
    unique case (chan_addr)
      hp_chain_pkg::CH_IRQ: local_word = irq_byte;
      hp_chain_pkg::CH_NONIRQ: local_word = nonirq_byte;
      hp_chain_pkg::CH_DIAG1: local_word = diag1_byte;
      hp_chain_pkg::CH_DIAG2: local_word = diag2_byte;
    endcase
  end

  // a low select while shifting is taken as a fresh start bit
  always_ff @(posedge clk_sys)
  begin
    if (srst || !operational)
    begin
      in_state <= IN_IDLE;
      chan_addr <= hp_chain_pkg::CH_IRQ;
    end
    else if (s_rise)
    begin
      unique case (in_state)
        IN_IDLE: if (!s_sel) in_state <= IN_LSB;
        IN_LSB:
        begin
          chan_addr[0] <= s_sel;
          in_state <= IN_MSB;
        end
        IN_MSB:
        begin
          chan_addr[1] <= s_sel;
          in_state <= IN_RSV;
        end
        IN_RSV: in_state <= IN_SHIFT;
        IN_SHIFT: if (!s_sel) in_state <= IN_LSB;
        default: in_state <= IN_IDLE;
      endcase
    end
  end

  // slot a byte sits at the low end so it leaves first
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      in_sr <= '0;
    end
    else if (s_rise && in_state == IN_RSV)
    begin
      in_sr <= local_word;
    end
    else if (s_rise && in_state == IN_SHIFT && s_sel)
    begin
      in_sr <= {s_chain, in_sr[NL-1:1]};
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst || !operational)
      link.status_chain_out <= 1'h0;
    else
      link.status_chain_out <= in_sr[0];
  end

  // control shift: first-shifted bits overflow toward downstream devices
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      out_sr <= '0;
    else if (operational && c_rise)
      out_sr <= {c_data, out_sr[NL-1:1]};
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst || !operational)
      control_chain_out <= 1'h0;
    else
      control_chain_out <= out_sr[0];
  end

endmodule

/* File: core/hp_chain_host.sv */
// hot-plug controller end of the chain, with its readback byte fifo

// fifo with a registered output stage; in_ready and out_valid are flops
module hp_byte_fifo #(
  parameter int WIDTH = hp_chain_pkg::FIFO_WIDTH,
  parameter int DEPTH = hp_chain_pkg::FIFO_DEPTH
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr, rd_ptr;
  logic [CW-1:0] count, next_count;
  logic push, pop;

  assign push = in_valid & in_ready;
  assign pop = (count != '0) && (!out_valid || out_ready);

  always_comb
  begin
    next_count = count;
    if (push && !pop)
      next_count = count + 1'b1;
    else if (pop && !push)
      next_count = count - 1'b1;
  end

  // storage write
  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'h0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;
      count <= next_count;
      in_ready <= next_count < CNT_FULL;
    end
  end

  // output stage refills whenever it is empty or being taken
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      out_valid <= 1'h0;
      out_data <= '0;
    end
    else if (pop)
    begin
      out_valid <= 1'h1;
      out_data <= mem[rd_ptr];
    end
    else if (out_ready)
    begin
      out_valid <= 1'h0;
    end
  end

endmodule

module hp_chain_host #(
  parameter int READ_BITS = hp_chain_pkg::CHAIN_BITS,
  parameter int WRITE_BITS = hp_chain_pkg::CHAIN_BITS
)
(
  input wire logic clk_sys,
  input wire logic srst,
  hp_chain_if.host link,
  input wire logic read_req,
  input wire logic [1:0] read_channel,
  input wire logic write_req,
  input wire logic [WRITE_BITS-1:0] write_data,
  output logic busy,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [hp_chain_pkg::FIFO_WIDTH-1:0] rd_data
);

  localparam int FW = hp_chain_pkg::FIFO_WIDTH;
  localparam int BW = $clog2(READ_BITS + WRITE_BITS + 1);
  localparam int HW = $clog2(hp_chain_pkg::LINK_HALF_CYCLES + 1);
  localparam logic [HW-1:0] HALF_LAST = HW'(hp_chain_pkg::LINK_HALF_CYCLES - 1);
  localparam logic [BW-1:0] SEL_BITS = BW'(hp_chain_pkg::ADDR_BITS + 1);

  typedef enum logic [2:0]
  {
    H_IDLE = 3'h0,
    H_SELECT = 3'h1,
    H_READ = 3'h3,
    H_WRITE = 3'h2,
    H_LATCH = 3'h6,
    H_RLATCH = 3'h7
  } host_state_type;

  host_state_type state;
  logic [HW-1:0] half_cnt;
  logic tick, link_high;
  logic [BW-1:0] bit_cnt;
  logic [3:0] sel_pattern;
  logic [WRITE_BITS-1:0] wr_sr;
  logic [FW-1:0] asm_sr;
  logic [$clog2(FW)-1:0] asm_cnt;
  logic st_meta, st_q;
  logic fifo_valid, fifo_ready;
  logic [FW-1:0] fifo_data;
  logic stall;

  // status pin is from the nearest device, so it is synchronised
  always_ff @(posedge clk_sys)
  begin
    st_meta <= link.status_chain_out;
    st_q <= st_meta;
  end

  // half-period divider for the link clocks
  always_ff @(posedge clk_sys)
  begin
    if (srst || state == H_IDLE)
    begin
      half_cnt <= '0;
      tick <= 1'h0;
    end
    else
    begin
      tick <= half_cnt == HALF_LAST;
      half_cnt <= (half_cnt == HALF_LAST) ? '0 : half_cnt + 1'b1;
    end
  end

  // a full fifo holds the link clock low, so readback never drops a byte
  assign stall = (state == H_READ) && !fifo_ready;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      state <= H_IDLE;
      link_high <= 1'h0;
      bit_cnt <= '0;
      sel_pattern <= 4'hf;
      wr_sr <= '0;
      busy <= 1'h0;
      link.status_shift_clock <= 1'h0;
      link.status_load_select <= 1'h1;
      link.control_shift_clock <= 1'h0;
      link.control_chain_in <= 1'h0;
      link.control_latch_clock <= 1'h0;
      link.reset_latch_clock <= 1'h0;
    end
    else if (state == H_IDLE)
    begin
      if (read_req)
      begin
        // start bit, lsb, msb, reserved high
        sel_pattern <= {1'h1, read_channel, 1'h0};
        link.status_load_select <= 1'h0;
        bit_cnt <= SEL_BITS;
        state <= H_SELECT;
        busy <= 1'h1;
      end
      else if (write_req)
      begin
        // the whole chain is reloaded; far slot bit 0 goes first
        link.control_chain_in <= write_data[0];
        wr_sr <= write_data >> 1;
        bit_cnt <= BW'(WRITE_BITS);
        state <= H_WRITE;
        busy <= 1'h1;
      end
    end
    else if (tick && !link_high && !stall)
    begin
      link_high <= 1'h1;
      link.status_shift_clock <= (state == H_SELECT) || (state == H_READ);
      link.control_shift_clock <= state == H_WRITE;
      link.control_latch_clock <= state == H_LATCH;
      link.reset_latch_clock <= state == H_RLATCH;
    end
    else if (tick && link_high)
    begin
      link_high <= 1'h0;
      link.status_shift_clock <= 1'h0;
      link.control_shift_clock <= 1'h0;
      link.control_latch_clock <= 1'h0;
      link.reset_latch_clock <= 1'h0;
      bit_cnt <= bit_cnt - 1'b1;
      sel_pattern <= {1'h1, sel_pattern[3:1]};
      link.status_load_select <= sel_pattern[1];
      link.control_chain_in <= wr_sr[0];
      wr_sr <= wr_sr >> 1;
      unique case (state)
        H_SELECT:
          if (bit_cnt == 1'b1)
          begin
            bit_cnt <= BW'(READ_BITS);
            state <= H_READ;
          end
        H_READ:
          if (bit_cnt == 1'b1)
          begin
            state <= H_IDLE;
            busy <= 1'h0;
          end
        H_WRITE: if (bit_cnt == 1'b1) state <= H_LATCH;
        H_LATCH: state <= H_RLATCH;
        H_RLATCH:
        begin
          state <= H_IDLE;
          busy <= 1'h0;
        end
        default: state <= H_IDLE;
      endcase
    end
  end

  // readback assembly: first received bit lands in bit 0 of each byte
  always_ff @(posedge clk_sys)
  begin
    if (srst || state != H_READ)
    begin
      asm_sr <= '0;
      asm_cnt <= '0;
      fifo_valid <= 1'h0;
      fifo_data <= '0;
    end
    else
    begin
      fifo_valid <= 1'h0;
      if (tick && !link_high && !stall)
      begin
        asm_sr <= {st_q, asm_sr[FW-1:1]};
        asm_cnt <= asm_cnt + 1'b1;
        if (asm_cnt == '1)
        begin
          fifo_valid <= 1'h1;
          fifo_data <= {st_q, asm_sr[FW-1:1]};
        end
      end
    end
  end

  hp_byte_fifo #(
    .WIDTH(FW),
    .DEPTH(hp_chain_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .srst(srst),
    .in_valid(fifo_valid),
    .in_ready(fifo_ready),
    .in_data(fifo_data),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

endmodule

/* File: dv/hp_chain_assertions.sv */
// serial link checker for the hot-plug chain
module hp_chain_assertions #(
  parameter int WRITE_BITS = hp_chain_pkg::CHAIN_BITS
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic status_shift_clock,
  input wire logic status_load_select,
  input wire logic status_chain_out,
  input wire logic control_shift_clock,
  input wire logic control_chain_in,
  input wire logic control_latch_clock,
  input wire logic reset_latch_clock
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] rises;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  // rises since the last main latch; a short write would leave stale slot bytes
  always_ff @(posedge clk_sys)
  begin
    if (srst || $rose(control_latch_clock))
      rises <= 8'h00;
    else if ($rose(control_shift_clock))
      rises <= rises + 8'h01;
  end
  a_idle_after_reset:
    assert property ($fell(srst) |-> !status_shift_clock && status_load_select)
    else $error("link busy after reset");
  a_start_bit:
    assert property ($fell(status_load_select) |-> (!status_load_select)[*8] ##[1:15]
      ($rose(status_shift_clock) && !status_load_select)) else $error("start bit bad");
  a_select_setup:
    assert property ($changed(status_load_select) |-> !status_shift_clock)
    else $error("select moved with clock high");
  a_ctl_data_setup:
    assert property ($changed(control_chain_in) |-> !control_shift_clock)
    else $error("control data moved with clock high");
  a_ctl_clock_high:
    assert property ($rose(control_shift_clock) |-> control_shift_clock[*8])
    else $error("control clock pulse short");
  a_full_chain:
    assert property ($rose(control_latch_clock) |-> rises == 8'(WRITE_BITS))
    else $error("latch after partial shift");
  a_latch_order:
    assert property ($rose(control_latch_clock) |-> ##[10:60] $rose(reset_latch_clock))
    else $error("reset latch missing");
  a_latch_quiet:
    assert property (control_latch_clock || reset_latch_clock |->
      !control_shift_clock && !status_shift_clock) else $error("latch during shift");
  a_status_moves:
    assert property ($changed(status_chain_out) |-> status_shift_clock)
    else $error("status out moved off clock");
  a_paths_apart:
    assert property (!(status_shift_clock && control_shift_clock))
    else $error("both shift clocks high");
  c_read: cover property ($fell(status_load_select));
  c_write: cover property ($rose(control_latch_clock));
  c_reset_latch: cover property ($rose(reset_latch_clock));
endmodule

/* File: dv/tb_top.sv */
// self-checking bench: chain host and slot device joined over the serial link
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic sci, pg, tst, rreq, wreq, busy, rvld, rrdy, cco, oper;
  logic drain, csc_d;
  logic [1:0] mode, lock, btn, mfn, afn, pr2, pr1, m66, cx1, cx2, rch, flt;
  logic [1:0] pwr, ckn, bsn, rsn, pled, aled;
  logic [7:0] rdat, ea, eb;
  logic [47:0] wdat, ser, wd;
  logic [7:0] rxq[$];
  int seed = 1;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  assign flt = ~(mfn & afn);
  hp_chain_if link ();
  hp_slot_device u_hp_slot_device (.clk_sys(clk_sys), .srst(srst), .link(link),
    .status_chain_in(sci), .control_chain_out(cco), .power_good_in(pg), .test_in(tst),
    .mode_in(mode), .slot_interlock_open(lock), .slot_button(btn), .slot_main_fault_n(mfn),
    .slot_aux_fault_n(afn), .slot_present2(pr2), .slot_present1(pr1), .slot_m66_enable(m66),
    .slot_pcix_cap1(cx1), .slot_pcix_cap2(cx2), .slot_power_enable(pwr),
    .slot_clock_enable_n(ckn), .slot_bus_enable_n(bsn), .slot_reset_out_n(rsn),
    .power_indicator(pled), .attention_indicator(aled), .operational(oper));
  hp_chain_host #(.READ_BITS(24)) u_hp_chain_host (.clk_sys(clk_sys), .srst(srst), .link(link),
    .read_req(rreq), .read_channel(rch), .write_req(wreq), .write_data(wdat), .busy(busy),
    .rd_valid(rvld), .rd_ready(rrdy), .rd_data(rdat));
  hp_chain_assertions #(.WRITE_BITS(hp_chain_pkg::CHAIN_BITS)) u_hp_chain_assertions (
    .clk_sys(clk_sys), .srst(srst), .status_shift_clock(link.status_shift_clock),
    .status_load_select(link.status_load_select), .status_chain_out(link.status_chain_out),
    .control_shift_clock(link.control_shift_clock), .control_chain_in(link.control_chain_in),
    .control_latch_clock(link.control_latch_clock), .reset_latch_clock(link.reset_latch_clock));
  initial
  begin
    forever #(hp_chain_pkg::CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
  end
  // serial control capture, random stalls of the reader, and the hang limit
  always @(posedge clk_sys)
  begin
    csc_d <= link.control_shift_clock;
    if (link.control_shift_clock === 1'b1 && csc_d === 1'b0)
      ser <= {link.control_chain_in, ser[47:1]};
    rrdy <= #1 drain & 1'($random(seed));
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      bad_count++;
      end_of_test();
    end
  end
  // sample handshakes mid-cycle, the transfer lands on the next rising edge
  always @(negedge clk_sys)
  begin
    if (rvld === 1'b1 && rrdy === 1'b1)
      rxq.push_back(rdat);
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [47:0] got, input logic [47:0] want);
    check_count++;
    if (got !== want)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h want=%h", $time, got, want);
    end
  endtask
  // slot pin states as diagnostic channel bits, faults forcing reset, clock and bus
  function automatic logic [7:0] pins(input logic [7:0] c, input logic f);
    return {1'b0, c[5], c[4], c[3] & ~f, ~c[2] | f, ~c[1] | f, c[0], 1'b1};
  endfunction
  function automatic logic [7:0] act(input int s);
    return {1'b0, aled[s], pled[s], rsn[s], bsn[s], ckn[s], pwr[s], 1'b1};
  endfunction
  function automatic logic [7:0] st_byte(input logic [1:0] ch, input int s);
    case (ch)
      2'h0: return {3'h0, pr1[s], pr2[s], mfn[s] & afn[s], btn[s], lock[s]};
      2'h1: return {4'h0, afn[s], cx2[s], cx1[s], m66[s]};
      2'h2: return pins(s == 0 ? ea : eb, flt[s]);
      default: return 8'h07;
    endcase
  endfunction
  task automatic do_read(input logic [1:0] ch);
    rxq.delete();
    {rreq, rch} = {1'b1, ch};
    @(posedge clk_sys);
    #1;
    rreq = 1'b0;
    wait (busy === 1'b0);
    repeat (40) @(posedge clk_sys);
    #1;
    check(48'(rxq.size()), 48'h3);
    check(48'(rxq[0]), 48'(st_byte(ch, 0)));
    check(48'(rxq[1]), 48'(st_byte(ch, 1)));
    check(48'(rxq[2]), 48'({8{sci}}));
  endtask
  task automatic do_write(input logic [47:0] w);
    {wreq, wdat} = {1'b1, w};
    @(posedge clk_sys);
    #1;
    wreq = 1'b0;
    wait (link.control_latch_clock === 1'b1);
    repeat (9) @(posedge clk_sys);
    #1;
    check(48'(pwr), 48'({w[32], w[40]}));
    check(48'(rsn), 48'({eb[3] & ~flt[1], ea[3] & ~flt[0]}));
    wait (busy === 1'b0);
    repeat (8) @(posedge clk_sys);
    #1;
    {ea, eb} = {w[47:40], w[39:32]};
    check(ser, w);
    check(48'(cco), 48'(w[32]));
    check(48'({act(0), act(1)}), 48'({pins(ea, flt[0]), pins(eb, flt[1])}));
  endtask
  initial
  begin
    {sci, pg, tst, rreq, wreq, drain} = 6'h01;
    {lock, btn, pr2, pr1, m66, cx1, cx2, rch} = 16'h0000;
    {mfn, afn, mode} = 6'h3f;
    {wdat, ea, eb} = {48'h0, 8'h30, 8'h30};
    repeat (12) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    // power-good with test high is a reserved mode, never operational
    {tst, pg} = 2'h3;
    repeat (20) @(posedge clk_sys);
    #1;
    check(48'(oper), 48'h0);
    // mode pins other than 11 leave the chain idle too
    {tst, pg, mode} = 4'h1;
    repeat (20) @(posedge clk_sys);
    #1;
    pg = 1'b1;
    repeat (20) @(posedge clk_sys);
    #1;
    check(48'(oper), 48'h0);
    {pg, mode} = 3'h3;
    repeat (20) @(posedge clk_sys);
    #1;
    pg = 1'b1;
    repeat (20) @(posedge clk_sys);
    #1;
    check(48'(oper), 48'h1);
    check(48'({act(0), act(1)}), 48'h6d6d);
    do_read(2'h2);
    for (int i = 0; i < 8; i++)
    begin
      {mfn, afn} = 4'hf;
      {lock, btn, pr2, pr1, m66, cx1, cx2} = 14'($random(seed));
      sci = 1'($random(seed));
      wd = (i == 0) ? 48'hffff_ffff_ffff : 48'({$random(seed), $random(seed)});
      do_write((i == 1) ? 48'h0 : wd);
      // faults land on top of latched controls, no latch clock involved
      {mfn, afn} = (i > 1) ? 4'($random(seed)) : 4'hf;
      repeat (8) @(posedge clk_sys);
      #1;
      check(48'({act(0), act(1)}), 48'({pins(ea, flt[0]), pins(eb, flt[1])}));
      // a faulted slot keeps reset, clock and bus forced off until it is relatched
      ea = flt[0] ? (ea & 8'hf1) : ea;
      eb = flt[1] ? (eb & 8'hf1) : eb;
      for (int c = 0; c < 4; c++) do_read(2'(c));
    end
    // hold the reader off until the readback buffer fills and the host stalls, then drain
    drain = 1'b0;
    rxq.delete();
    for (int r = 0; r < 12; r++)
    begin
      {rreq, rch} = 3'h7;
      @(posedge clk_sys);
      #1;
      rreq = 1'b0;
      if (r < 11)
      begin
        wait (busy === 1'b0);
        @(posedge clk_sys);
        #1;
      end
    end
    repeat (800) @(posedge clk_sys);
    #1;
    check(48'({busy, 8'(rxq.size())}), 48'h100);
    drain = 1'b1;
    wait (busy === 1'b0);
    repeat (80) @(posedge clk_sys);
    #1;
    check(48'(rxq.size()), 48'h24);
    for (int k = 0; k < 36; k++)
    begin
      check(48'(rxq[k]), (k % 3 == 2) ? 48'({8{sci}}) : 48'(st_byte(2'h3, 0)));
    end
    end_of_test();
  end
endmodule
